// ### hw/lbat_defines.svh
// constants for the local bus arbiter and access timer
`ifndef LBAT_DEFINES_SVH
`define LBAT_DEFINES_SVH
`define LBAT_CLK_MHZ      100
`define LBAT_US_CYC       ((`LBAT_CLK_MHZ * 1000) / 1000)
`define LBAT_US_CNT_W     7
`define LBAT_US_LAST      7'h63
`define LBAT_TO_8_US      12'h008
`define LBAT_TO_64_US     12'h040
`define LBAT_TO_256_US    12'h100
`define LBAT_TO_CNT_W     12
`define LBAT_TO_SEL_8     2'h0
`define LBAT_TO_SEL_64    2'h1
`define LBAT_TO_SEL_256   2'h2
`define LBAT_TO_SEL_INF   2'h3
`define LBAT_NMST         5
`define LBAT_IDX_NET      0
`define LBAT_IDX_MOD      1
`define LBAT_IDX_DISK     2
`define LBAT_IDX_BRIDGE   3
`define LBAT_IDX_CPU      4
`endif

// ### hw/lbat_pkg.sv
// types for the local bus arbiter and access timer
package lbat_pkg;
   typedef logic [4:0] lbat_mvec_t;
   typedef logic [1:0] lbat_tosel_t;
   typedef enum logic [1:0] {
      LBAT_IDLE  = 2'b00,
      LBAT_OWNED = 2'b01,
      LBAT_XFER  = 2'b10
   } lbat_state_t;
endpackage

// ### hw/lbat_access_timer.sv
// local bus access timer with microsecond prescaler
`timescale 1ns/10ps
`include "lbat_defines.svh"
module lbat_access_timer
   import lbat_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              clk_en,
   input  wire logic              run,
   input  wire logic              restart,
   input  wire lbat_pkg::lbat_tosel_t to_sel,
   output logic                   expired
);
   import lbat_pkg::*;
   logic [`LBAT_US_CNT_W-1:0] us_ff, nxt_us;
   logic [`LBAT_TO_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [`LBAT_TO_CNT_W-1:0] limit;

   always_comb begin
      nxt_us  = us_ff;
      nxt_cnt = cnt_ff;
      unique case (to_sel)
         `LBAT_TO_SEL_8:   limit = `LBAT_TO_8_US;
         `LBAT_TO_SEL_64:  limit = `LBAT_TO_64_US;
         `LBAT_TO_SEL_256: limit = `LBAT_TO_256_US;
         default:          limit = '0;
      endcase
      if (restart) begin
         nxt_us  = '0;
         nxt_cnt = '0;
      end else if (run) begin
         if (us_ff == `LBAT_US_LAST) begin
            nxt_us = '0;
            if (cnt_ff != limit)
               nxt_cnt = cnt_ff + `LBAT_TO_CNT_W'(1);
         end else begin
            nxt_us = us_ff + `LBAT_US_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         us_ff  <= '0;
         cnt_ff <= '0;
      end else if (clk_en) begin
         us_ff  <= nxt_us;
         cnt_ff <= nxt_cnt;
      end
   end

   // infinite setting has limit zero, so the count stays at zero and matches it; the to_sel term keeps expired low
   assign expired = run && (to_sel != `LBAT_TO_SEL_INF) && (cnt_ff == limit)
                    && (cnt_ff != '0);
endmodule // lbat_access_timer

// ### hw/lbat_arbiter.sv
// local bus fixed-priority arbiter with access timeout
// Operation
// - grant by fixed priority: network, module dma, disk, bridge, then processor
// - timer enabled and access too long: transfer error ack to bus owner
// - timeout selectable 8, 64, 256 us or infinite; infinite never fires
// - timer does not count during cycles bound for the system bus
// - own timer acts only when system-bus interface chip absent
// - duplicated timeout inhibited while system-bus interface chip present
// - unclaimed onboard address access ends in timeout when timer enabled with a finite setting and system-bus interface chip absent
`timescale 1ns/10ps
`include "lbat_defines.svh"
module lbat_arbiter
   import lbat_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  clk_en,
   input  wire lbat_pkg::lbat_mvec_t  bus_req,
   input  wire logic                  xfer_start,
   input  wire logic                  xfer_ack,
   input  wire logic                  xfer_offboard,
   input  wire logic                  timer_en,
   input  wire lbat_pkg::lbat_tosel_t timeout_sel,
   input  wire logic                  sysif_present,
   output lbat_pkg::lbat_mvec_t       bus_grant,
   output logic                       transfer_error_ack,
   output logic                       bus_busy
);
   import lbat_pkg::*;

   lbat_state_t state_ff, nxt_state;
   lbat_mvec_t  grant_ff, nxt_grant;
   logic        tea_ff, nxt_tea;
   logic        offb_ff, nxt_offb;
   logic        busy_ff, nxt_busy;
   logic        present_s1_ff, present_s2_ff;
   logic        timer_run, timer_restart, expired;

   // fixed priority pick: lowest index wins
   function automatic lbat_mvec_t pick(input lbat_mvec_t req);
      lbat_mvec_t g;
      g = '0;
      for (int i = `LBAT_NMST - 1; i >= 0; i--) begin
         if (req[i])
            g = lbat_mvec_t'(1) << i;
      end
      return g;
   endfunction

   // strap from the board: synchronise before use
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         present_s1_ff <= 1'b0;
         present_s2_ff <= 1'b0;
      end else if (clk_en) begin
         present_s1_ff <= sysif_present;
         present_s2_ff <= present_s1_ff;
      end
   end

   // offboard cycles and the presence of the other chip both stop the count
   assign timer_run     = (state_ff == LBAT_XFER) && timer_en && !present_s2_ff
                          && !offb_ff;
   assign timer_restart = (state_ff != LBAT_XFER) || xfer_ack;

   lbat_access_timer u_timer (
      .clk     (clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .run     (timer_run),
      .restart (timer_restart),
      .to_sel  (timeout_sel),
      .expired (expired)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_grant = grant_ff;
      nxt_tea   = 1'b0;
      nxt_offb  = offb_ff;
      nxt_busy  = busy_ff;
      unique case (state_ff)
         LBAT_IDLE: begin
            nxt_busy = 1'b0;
            if (bus_req != '0) begin
               nxt_grant = pick(bus_req);
               nxt_state = LBAT_OWNED;
            end
         end
         LBAT_OWNED: begin
            if ((bus_req & grant_ff) == '0) begin
               nxt_grant = '0;
               nxt_state = LBAT_IDLE;
            end else if (xfer_start) begin
               nxt_offb  = xfer_offboard;
               nxt_busy  = 1'b1;
               nxt_state = LBAT_XFER;
            end
         end
         LBAT_XFER: begin
            // no decoder answers an unclaimed address, so only the timer ends it
            if (xfer_ack) begin
               nxt_busy  = 1'b0;
               nxt_state = LBAT_OWNED;
            end else if (expired) begin
               nxt_tea   = 1'b1;
               nxt_busy  = 1'b0;
               nxt_state = LBAT_OWNED;
            end
         end
         default: begin
            nxt_state = LBAT_IDLE;
            nxt_grant = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= LBAT_IDLE;
         grant_ff <= '0;
         tea_ff   <= 1'b0;
         offb_ff  <= 1'b0;
         busy_ff  <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         grant_ff <= nxt_grant;
         tea_ff   <= nxt_tea;
         offb_ff  <= nxt_offb;
         busy_ff  <= nxt_busy;
      end
   end

   assign bus_grant          = grant_ff;
   assign transfer_error_ack = tea_ff;
   assign bus_busy           = busy_ff;

   property p_prio_grant;
      @(posedge clk) disable iff (!arst_n)
      (state_ff == LBAT_IDLE && bus_req != '0 && clk_en) |=> (bus_grant == pick($past(bus_req)));
   endproperty
   a_prio_grant: assert property (p_prio_grant) else $error("grant not by priority");

   property p_net_wins;
      @(posedge clk) disable iff (!arst_n)
      (state_ff == LBAT_IDLE && bus_req[`LBAT_IDX_NET] && clk_en) |=> bus_grant[`LBAT_IDX_NET];
   endproperty
   a_net_wins: assert property (p_net_wins) else $error("network master not granted");

   property p_tea_owner;
      @(posedge clk) disable iff (!arst_n)
      transfer_error_ack |-> (bus_grant != '0 && $past(state_ff) == LBAT_XFER);
   endproperty
   a_tea_owner: assert property (p_tea_owner) else $error("error ack without owner");

   property p_tea_cause;
      @(posedge clk) disable iff (!arst_n)
      (expired && state_ff == LBAT_XFER && !xfer_ack && clk_en) |=> transfer_error_ack;
   endproperty
   a_tea_cause: assert property (p_tea_cause) else $error("expiry without error ack");

   property p_inf_never;
      @(posedge clk) disable iff (!arst_n)
      (timeout_sel == `LBAT_TO_SEL_INF) |-> !expired;
   endproperty
   a_inf_never: assert property (p_inf_never) else $error("infinite timeout expired");

   property p_offboard_quiet;
      @(posedge clk) disable iff (!arst_n)
      (state_ff == LBAT_XFER && offb_ff) |-> !timer_run;
   endproperty
   a_offboard_quiet: assert property (p_offboard_quiet) else $error("timer ran offboard");

   property p_present_inhibit;
      @(posedge clk) disable iff (!arst_n)
      present_s2_ff |=> !transfer_error_ack;
   endproperty
   a_present_inhibit: assert property (p_present_inhibit) else $error("timeout while inhibited");

   property p_ack_restart;
      @(posedge clk) disable iff (!arst_n)
      (state_ff == LBAT_XFER && xfer_ack && clk_en) |=> (state_ff == LBAT_OWNED && !bus_busy);
   endproperty
   a_ack_restart: assert property (p_ack_restart) else $error("ack did not end transfer");

   // at most one master may ever drive the local bus
   property p_grant_onehot;
      @(posedge clk) disable iff (!arst_n)
      $onehot0(bus_grant);
   endproperty
   a_grant_onehot: assert property (p_grant_onehot) else $error("grant not one-hot");

   // no preemption: a higher request waits until the owner lets go
   property p_grant_hold;
      @(posedge clk) disable iff (!arst_n)
      (state_ff == LBAT_OWNED && (bus_req & bus_grant) != '0 && clk_en) |=> $stable(bus_grant);
   endproperty
   a_grant_hold: assert property (p_grant_hold) else $error("owner lost the bus");

   property p_grant_release;
      @(posedge clk) disable iff (!arst_n)
      (state_ff == LBAT_OWNED && (bus_req & bus_grant) == '0 && clk_en) |=> (bus_grant == '0);
   endproperty
   a_grant_release: assert property (p_grant_release) else $error("grant kept after release");

   property p_tea_pulse;
      @(posedge clk) disable iff (!arst_n)
      (transfer_error_ack && clk_en) |=> !transfer_error_ack;
   endproperty
   a_tea_pulse: assert property (p_tea_pulse) else $error("error ack longer than one cycle");

   property p_timer_off_quiet;
      @(posedge clk) disable iff (!arst_n)
      (!timer_en && clk_en) |=> !transfer_error_ack;
   endproperty
   a_timer_off_quiet: assert property (p_timer_off_quiet) else $error("error ack with timer off");

   // offboard cycles belong to the system-bus timers, never to this one
   property p_offboard_no_tea;
      @(posedge clk) disable iff (!arst_n)
      (state_ff == LBAT_XFER && offb_ff && clk_en) |=> !transfer_error_ack;
   endproperty
   a_offboard_no_tea: assert property (p_offboard_no_tea) else $error("error ack offboard");

   property p_busy_start;
      @(posedge clk) disable iff (!arst_n)
      (state_ff == LBAT_OWNED && (bus_req & bus_grant) != '0 && xfer_start && clk_en)
         |=> bus_busy;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("start did not open transfer");
endmodule // lbat_arbiter

// ### test/lbat_slave_model.sv
// far-side slave model that acknowledges local bus transfers
`timescale 1ns/10ps
module lbat_slave_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        bus_busy,
   input  wire logic [15:0] ack_dly,
   input  wire logic        no_ack,
   output logic             xfer_ack
);
   logic [15:0] cnt_ff;
   logic        done_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff   <= 16'h0000;
         done_ff  <= 1'b0;
         xfer_ack <= 1'b0;
      end else begin
         xfer_ack <= 1'b0;
         if (!bus_busy) begin
            cnt_ff  <= 16'h0000;
            done_ff <= 1'b0;
         end else begin
            cnt_ff <= cnt_ff + 16'h0001;
            // an unclaimed address has no decoder, so nothing ever answers
            if (!no_ack && !done_ff && cnt_ff >= ack_dly) begin
               xfer_ack <= 1'b1;
               done_ff  <= 1'b1;
            end
         end
      end
   end
endmodule // lbat_slave_model

// ### test/tb_local_bus_arbiter_timeout.sv
// self-checking bench for the local bus arbiter and access timer
`timescale 1ns/10ps
module tb_local_bus_arbiter_timeout;
   import lbat_pkg::*;
   logic        clk, arst_n, xfer_start, xfer_ack, xfer_offboard;
   logic        timer_en, sysif_present, no_ack, transfer_error_ack, bus_busy;
   logic        clk_en;
   lbat_mvec_t  bus_req, bus_grant, gprev, v, g;
   lbat_tosel_t timeout_sel;
   logic [15:0] ack_dly;
   int          err_total, cmp_count, cyc, t0, lim;
   int          lims[3] = '{800, 6400, 25600};
   lbat_mvec_t  gq[$];
   int          tq[$];

   lbat_arbiter uut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .bus_req(bus_req),
      .xfer_start(xfer_start), .xfer_ack(xfer_ack), .xfer_offboard(xfer_offboard),
      .timer_en(timer_en), .timeout_sel(timeout_sel), .sysif_present(sysif_present),
      .bus_grant(bus_grant), .transfer_error_ack(transfer_error_ack), .bus_busy(bus_busy));
   lbat_slave_model slave (.clk(clk), .arst_n(arst_n), .bus_busy(bus_busy),
      .ack_dly(ack_dly), .no_ack(no_ack), .xfer_ack(xfer_ack));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic fail(input string msg);
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) fail(msg);
   endtask
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // results are sampled mid-cycle, away from the launching edge
   always @(negedge clk) begin
      cyc = cyc + 1;
      if (cyc > 60000) begin
         fail("run exceeded cycle ceiling");
         test_done();
      end
      if (gprev === 5'h00 && bus_grant !== 5'h00) begin
         if (gq.size() == 0) fail("unexpected grant");
         else chk(bus_grant === gq.pop_front(), "wrong grant");
      end
      gprev = bus_grant;
      if (transfer_error_ack === 1'b1) begin
         if (tq.size() == 0) fail("unexpected error ack");
         else begin
            lim = tq.pop_front();
            chk(cyc - t0 >= lim - 1 && cyc - t0 <= lim + 5, "timeout length");
         end
      end
   end

   task automatic get_bus(input lbat_mvec_t req);
      lbat_mvec_t e;
      int n;
      e = req & (~req + 5'h01);
      gq.push_back(e);
      bus_req <= req;
      for (n = 0; n < 10 && bus_grant !== e; n++) @(negedge clk);
      @(posedge clk);
   endtask

   task automatic xfer(input logic offb, input logic [15:0] dly, input logic noack,
                       input int limit);
      int n;
      @(posedge clk);
      xfer_offboard <= offb;
      ack_dly       <= dly;
      no_ack        <= noack;
      xfer_start    <= 1'b1;
      t0 = cyc;
      if (limit > 0) tq.push_back(limit);
      @(posedge clk);
      xfer_start <= 1'b0;
      @(negedge clk);
      chk(bus_busy === 1'b1, "busy missing after start");
      for (n = 0; n < 30000 && bus_busy !== 1'b0; n++) @(negedge clk);
      chk(bus_busy === 1'b0, "transfer never ended");
      @(posedge clk);
   endtask

   initial begin
      {arst_n, xfer_start, xfer_offboard, timer_en, sysif_present, no_ack} = '0;
      bus_req = 5'h00;
      clk_en = 1'b1;
      timeout_sel = 2'h0;
      ack_dly = 16'h0000;
      gprev = 5'h00;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      void'($urandom(32'h166d));
      timer_en <= 1'b1;
      repeat (2) @(posedge clk);
      repeat (6) begin
         v = lbat_mvec_t'($urandom_range(31, 1));
         g = v & (~v + 5'h01);
         get_bus(v);
         bus_req <= 5'h1f;
         repeat (4) @(negedge clk);
         chk(bus_grant === g, "owner preempted");
         @(posedge clk);
         // a frozen arbiter must ignore the release until the enable returns
         clk_en  <= 1'b0;
         bus_req <= 5'h00;
         repeat (4) @(negedge clk);
         chk(bus_grant === g, "grant moved while frozen");
         @(posedge clk);
         clk_en <= 1'b1;
         get_bus(5'h1f & ~g);
         bus_req <= 5'h00;
         repeat (3) @(posedge clk);
      end
      get_bus(5'h10);
      xfer(1'b0, 16'($urandom_range(20, 1)), 1'b0, 0);
      for (int s = 0; s < 3; s++) begin
         timeout_sel <= lbat_tosel_t'(s);
         xfer(1'b0, 16'h0000, 1'b1, lims[s]);
      end
      timeout_sel <= 2'h3;
      xfer(1'b0, 16'h07d0, 1'b0, 0);
      timeout_sel <= 2'h0;
      xfer(1'b1, 16'h03e8, 1'b0, 0);
      timer_en <= 1'b0;
      xfer(1'b0, 16'h03e8, 1'b0, 0);
      timer_en <= 1'b1;
      sysif_present <= 1'b1;
      repeat (4) @(posedge clk);
      xfer(1'b0, 16'h03e8, 1'b0, 0);
      sysif_present <= 1'b0;
      repeat (4) @(posedge clk);
      xfer(1'b0, 16'h0000, 1'b1, 800);
      bus_req <= 5'h00;
      repeat (3) @(posedge clk);
      chk(gq.size() == 0 && tq.size() == 0, "expected result never seen");
      test_done();
   end
endmodule // tb_local_bus_arbiter_timeout
